// [shared/mtr_pkg.sv]
// Register map, field layout and reset values of the threshold/output/unlock
// register bank. Shared by the core and the bench.
package mtr_pkg;

  // Direct register addresses
  localparam logic [5:0] MTR_ADDR_LOCK_KEY  = 6'h1E;
  localparam logic [5:0] MTR_ADDR_CTRL_SEL  = 6'h18;
  localparam logic [5:0] MTR_ADDR_CTRL_DATA = 6'h22;
  localparam logic [5:0] MTR_ADDR_STATUS    = 6'h02;

  // Indirect selector indices
  localparam logic [4:0] MTR_SEL_Y_TH     = 5'h03;
  localparam logic [4:0] MTR_SEL_X_TH     = 5'h04;
  localparam logic [4:0] MTR_SEL_Z_THRESH = 5'h05;
  localparam logic [4:0] MTR_SEL_BUF_CFG  = 5'h0B;

  // Unlock key bytes, in order
  localparam logic [7:0] MTR_KEY_0 = 8'h00;
  localparam logic [7:0] MTR_KEY_1 = 8'h50;
  localparam logic [7:0] MTR_KEY_2 = 8'hA0;

  // Threshold reset value per product variant
  localparam logic [7:0] MTR_TH_RST_A = 8'h10;
  localparam logic [7:0] MTR_TH_RST_B = 8'h08;
  localparam logic [7:0] MTR_TH_RST_C = 8'h1B;

  // Output control fields
  localparam int         MTR_OC_X_BIT   = 4;
  localparam int         MTR_OC_Y_BIT   = 3;
  localparam int         MTR_OC_Z_BIT   = 2;
  localparam logic [7:0] MTR_OC_RST     = 8'h1C;
  localparam logic [7:0] MTR_OC_MASK    = 8'h1F;
  localparam logic [7:0] MTR_XZ_TH_MASK = 8'h3F;
  localparam logic [7:0] MTR_Y_TH_MASK  = 8'h7F;
  localparam int         MTR_STATUS_LOCK_BIT = 5;

  // Buffer rate field codes
  localparam logic [1:0] MTR_RATE_DIV2 = 2'h1;
  localparam logic [1:0] MTR_RATE_DIV4 = 2'h2;

  typedef enum logic [1:0] {
    MTR_VAR_A,
    MTR_VAR_B,
    MTR_VAR_C
  } mtr_variant_e;

  // Unlock sequence progress
  typedef enum logic [1:0] {
    MTR_LK_IDLE,
    MTR_LK_GOT0,
    MTR_LK_GOT1,
    MTR_LK_OPEN
  } mtr_lock_e;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } mtr_req_s;

  // Thresholds as used by the motion detector
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } mtr_thresh_s;

  // Ring buffer path controls
  typedef struct packed {
    logic x_en;
    logic y_en;
    logic z_en;
    logic keep;
  } mtr_buf_ctl_s;

endpackage

// [core/mtr_regs.sv]
// Threshold, output control and unlock registers of the accelerometer.
// Assumes a serial frame decoder delivering one access per req_valid_i
// pulse, synchronous to clock_i.
`timescale 1ns/100ps

// What this block does
// - Hold 8-bit Z threshold for motion detector
// - Thresholds reset to variant constant 10h/08h/1Bh
// - Thresholds are unsigned absolute magnitudes
// - X,Z use bits 5:0; Y uses 6:0
// - Output bit 4 enables X buffering
// - Output bit 3 enables Y buffering
// - Output bit 2 enables Z buffering
// - Rate field: 10 quarter, 01 half, else full
// - Rate reduction only on ring buffer path
// - Key 00h,50h,A0h in order opens lock
// - Any wrong key byte closes lock
// - Lock state readable as status bit
// - Output control at selector index 01011
// - Z threshold at selector index 00101
// - Selector points data register at target
// - Data register write updates selected register, only while unlocked
// - Selector writes only accepted while unlocked
module mtr_regs #(
  parameter mtr_pkg::mtr_variant_e VARIANT = mtr_pkg::MTR_VAR_A
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // Register access
  input  wire logic                 req_valid_i,
  input  wire mtr_pkg::mtr_req_s    req_i,
  output logic [7:0]                rdata_o,
  // Calibrated sample strobe toward buffer path
  input  wire logic                 sample_i,
  // Motion detector and buffer controls
  output mtr_pkg::mtr_thresh_s      thresh_o,
  output mtr_pkg::mtr_buf_ctl_s     buf_ctl_o,
  output logic                      unlocked_o
);
  import mtr_pkg::*;

  localparam logic [7:0] TH_RST = (VARIANT == MTR_VAR_B) ? MTR_TH_RST_B :
                                  (VARIANT == MTR_VAR_C) ? MTR_TH_RST_C :
                                                           MTR_TH_RST_A;

  mtr_lock_e  lock_q, lock_d;
  logic [7:0] key_q, key_d;
  logic [4:0] sel_q, sel_d;
  logic [7:0] xth_q, xth_d, yth_q, yth_d, zth_q, zth_d;
  logic [7:0] oc_q, oc_d;
  logic [7:0] ind_rd;
  logic [1:0] div_q, div_d;
  logic       keep_q, keep_d;
  logic [7:0] rdata_q, rdata_d;
  logic       wr_key, wr_sel, wr_data;

  assign wr_key  = req_valid_i && req_i.wr && req_i.addr == MTR_ADDR_LOCK_KEY;
  assign wr_sel  = req_valid_i && req_i.wr && req_i.addr == MTR_ADDR_CTRL_SEL;
  assign wr_data = req_valid_i && req_i.wr && req_i.addr == MTR_ADDR_CTRL_DATA;

  // Unlock sequence
  always_comb begin
    lock_d = lock_q;
    key_d  = key_q;
    if (wr_key) begin
      key_d = req_i.wdata;
      unique case (lock_q)
        MTR_LK_IDLE, MTR_LK_OPEN: lock_d = (req_i.wdata == MTR_KEY_0) ?
                                           MTR_LK_GOT0 : MTR_LK_IDLE;
        MTR_LK_GOT0: lock_d = (req_i.wdata == MTR_KEY_1) ?
                              MTR_LK_GOT1 : MTR_LK_IDLE;
        MTR_LK_GOT1: lock_d = (req_i.wdata == MTR_KEY_2) ?
                              MTR_LK_OPEN : MTR_LK_IDLE;
      endcase
    end
  end

  // Indirect register writes
  always_comb begin
    sel_d = sel_q;
    xth_d = xth_q;
    yth_d = yth_q;
    zth_d = zth_q;
    oc_d  = oc_q;
    if (wr_sel && lock_q == MTR_LK_OPEN)
      sel_d = req_i.wdata[4:0];
    if (wr_data && lock_q == MTR_LK_OPEN) begin
      unique case (sel_q)
        MTR_SEL_X_TH:     xth_d = req_i.wdata;
        MTR_SEL_Y_TH:     yth_d = req_i.wdata;
        MTR_SEL_Z_THRESH: zth_d = req_i.wdata;
        MTR_SEL_BUF_CFG:  oc_d  = req_i.wdata & MTR_OC_MASK;
        default:          ;
      endcase
    end
  end

  always_comb begin
    unique case (sel_q)
      MTR_SEL_X_TH:     ind_rd = xth_q;
      MTR_SEL_Y_TH:     ind_rd = yth_q;
      MTR_SEL_Z_THRESH: ind_rd = zth_q;
      MTR_SEL_BUF_CFG:  ind_rd = oc_q;
      default:          ind_rd = 8'h00;
    endcase
  end

  // Read data, registered one cycle after request
  always_comb begin
    rdata_d = rdata_q;
    if (req_valid_i && !req_i.wr) begin
      unique case (req_i.addr)
        MTR_ADDR_LOCK_KEY:  rdata_d = key_q;
        MTR_ADDR_CTRL_SEL:  rdata_d = {3'h0, sel_q};
        MTR_ADDR_CTRL_DATA: rdata_d = ind_rd;
        MTR_ADDR_STATUS:    rdata_d = (lock_q == MTR_LK_OPEN) ?
                                      (8'h01 << MTR_STATUS_LOCK_BIT) :
                                      8'h00;
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  // Buffer rate reduction; direct outputs unaffected
  always_comb begin
    div_d  = div_q;
    keep_d = 1'b0;
    if (sample_i) begin
      div_d = 2'(div_q + 2'h1);
      unique case (oc_q[1:0])
        MTR_RATE_DIV2: keep_d = (div_q[0] == 1'b0);
        MTR_RATE_DIV4: keep_d = (div_q == 2'h0);
        default:       keep_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q  <= MTR_LK_IDLE;
      key_q   <= 8'h00;
      sel_q   <= 5'h00;
      xth_q   <= TH_RST;
      yth_q   <= TH_RST;
      zth_q   <= TH_RST;
      oc_q    <= MTR_OC_RST;
      div_q   <= 2'h0;
      keep_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      lock_q  <= lock_d;
      key_q   <= key_d;
      sel_q   <= sel_d;
      xth_q   <= xth_d;
      yth_q   <= yth_d;
      zth_q   <= zth_d;
      oc_q    <= oc_d;
      div_q   <= div_d;
      keep_q  <= keep_d;
      rdata_q <= rdata_d;
    end
  end

  // Only used bits reach the detector, unsigned
  assign thresh_o.x = xth_q & MTR_XZ_TH_MASK;
  assign thresh_o.y = yth_q & MTR_Y_TH_MASK;
  assign thresh_o.z = zth_q & MTR_XZ_TH_MASK;
  assign buf_ctl_o.x_en = oc_q[MTR_OC_X_BIT];
  assign buf_ctl_o.y_en = oc_q[MTR_OC_Y_BIT];
  assign buf_ctl_o.z_en = oc_q[MTR_OC_Z_BIT];
  assign buf_ctl_o.keep = keep_q;
  assign unlocked_o     = (lock_q == MTR_LK_OPEN);
  assign rdata_o        = rdata_q;

  AST_KEY_OPENS: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_key && req_i.wdata == MTR_KEY_2 && lock_q == MTR_LK_GOT1)
    |=> unlocked_o)
    else $error("key sequence did not open lock");
  // Only the final key byte after the first two may open the lock
  AST_BAD_KEY_CLOSES: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_key && !(req_i.wdata == MTR_KEY_2 && lock_q == MTR_LK_GOT1))
    |=> !unlocked_o)
    else $error("wrong key left lock open");
  AST_SEL_LOCKED: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !unlocked_o |=> $stable(sel_q))
    else $error("selector changed while locked");
  AST_SEL_WRITE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_sel && unlocked_o) |=> sel_q == $past(req_i.wdata[4:0]))
    else $error("selector write lost");
  AST_Z_WRITE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_data && unlocked_o && sel_q == MTR_SEL_Z_THRESH)
    |=> zth_q == $past(req_i.wdata))
    else $error("Z threshold not written");
  AST_Z_HOLD: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !wr_data |=> $stable(zth_q))
    else $error("Z threshold changed");
  AST_DATA_LOCKED: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !unlocked_o |=> $stable(oc_q))
    else $error("output control changed while locked");
  AST_OC_RSVD: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    oc_q[7:5] == 3'h0)
    else $error("reserved output bits set");
  AST_OC_WRITE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_data && unlocked_o && sel_q == MTR_SEL_BUF_CFG)
    |=> buf_ctl_o.x_en == $past(req_i.wdata[MTR_OC_X_BIT]))
    else $error("output control write lost");
  AST_DIV2: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (sample_i && oc_q[1:0] == MTR_RATE_DIV2 && div_q[0])
    |=> !buf_ctl_o.keep)
    else $error("divide by two leaked sample");
  AST_DIV4: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (sample_i && oc_q[1:0] == MTR_RATE_DIV4 && div_q != 2'h0)
    |=> !buf_ctl_o.keep)
    else $error("divide by four leaked sample");
  AST_STATUS: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_valid_i && !req_i.wr && req_i.addr == MTR_ADDR_STATUS)
    |=> rdata_o[MTR_STATUS_LOCK_BIT] == $past(unlocked_o))
    else $error("status lock bit wrong");
endmodule

// [test/mtr_host_model.sv]
// Host model: issues single-byte register accesses to the bank.
// Assumes requests are taken at the rising edge of clock_i.
`timescale 1ns/100ps
module mtr_host_model (
  // Clock
  input  wire logic          clock_i,
  // Requests and read data
  output logic               req_valid_o,
  output mtr_pkg::mtr_req_s  req_o,
  input  wire logic [7:0]    rdata_i
);
  import mtr_pkg::*;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // Call just after a rising edge; returns on a rising edge
  task automatic access(input logic w, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    req_valid_o <= 1'b1;
    req_o <= {w, a, d};
    @(posedge clock_i);
    req_valid_o <= 1'b0;
    // Released fields do not keep the old value
    req_o <= {1'b0, ~a, ~d};
    @(posedge clock_i);
    #1 q = rdata_i;
    @(posedge clock_i);
  endtask
endmodule

// [test/tb_mtr_regs.sv]
// Bench for the threshold, output control and unlock register bank.
// Assumes the host model drives every register access.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_mtr_regs;
  import mtr_pkg::*;
  logic         clock_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         sample_i = 1'b0;
  logic         req_valid;
  mtr_req_s     req;
  logic [7:0]   rdata;
  logic [7:0]   q;
  mtr_thresh_s  thresh;
  mtr_buf_ctl_s buf_ctl;
  logic         unlocked;
  int           num_errors = 0;
  int           checked = 0;
  int           keeps = 0;
  always #50 clock_i = ~clock_i;
  mtr_host_model host_u (.clock_i(clock_i), .req_valid_o(req_valid),
                         .req_o(req), .rdata_i(rdata));
  mtr_regs #(.VARIANT(MTR_VAR_C)) dut_u (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .req_valid_i(req_valid), .req_i(req),
    .rdata_o(rdata), .sample_i(sample_i), .thresh_o(thresh),
    .buf_ctl_o(buf_ctl), .unlocked_o(unlocked));
  always @(posedge clock_i) begin
    if (buf_ctl.keep === 1'b1) keeps <= keeps + 1;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    host_u.access(1'b0, a, 8'h00, q);
  endtask
  task automatic sel(input logic [4:0] i, input logic [7:0] d);
    wr(MTR_ADDR_CTRL_SEL, {3'h0, i});
    wr(MTR_ADDR_CTRL_DATA, d);
  endtask
  task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
    wr(MTR_ADDR_LOCK_KEY, MTR_KEY_0);
    wr(MTR_ADDR_LOCK_KEY, k1);
    wr(MTR_ADDR_LOCK_KEY, k2);
  endtask
  task automatic complete_run();
    $display("errors=%0d checked=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock_i);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    `CHK(thresh, {8'h1B, 8'h1B, 8'h1B})
    `CHK(buf_ctl, 4'hE)
    rd(MTR_ADDR_STATUS);
    `CHK(q[MTR_STATUS_LOCK_BIT], 1'b0)
    wr(MTR_ADDR_CTRL_SEL, 8'h05);
    rd(MTR_ADDR_CTRL_SEL);
    `CHK(q, 8'h00)
    keys(8'h50, 8'h55);
    `CHK(unlocked, 1'b0)
    keys(MTR_KEY_1, MTR_KEY_2);
    `CHK(unlocked, 1'b1)
    rd(MTR_ADDR_STATUS);
    `CHK(q[MTR_STATUS_LOCK_BIT], 1'b1)
    sel(MTR_SEL_Z_THRESH, 8'hFF);
    `CHK(thresh, {8'h1B, 8'h1B, 8'h3F})
    rd(MTR_ADDR_CTRL_DATA);
    `CHK(q, 8'hFF)
    sel(MTR_SEL_Y_TH, 8'hFF);
    `CHK(thresh.y, 8'h7F)
    sel(MTR_SEL_X_TH, 8'hC5);
    `CHK(thresh.x, 8'h05)
    sel(MTR_SEL_BUF_CFG, 8'hFF);
    rd(MTR_ADDR_CTRL_DATA);
    `CHK(q, 8'h1F)
    for (int b = 2; b < 5; b++) begin
      sel(MTR_SEL_BUF_CFG, 8'h1C & ~(8'h01 << b));
      `CHK(buf_ctl[3:1], 3'h7 & ~(3'h1 << (b - 2)))
    end
    for (int c = 0; c < 4; c++) begin
      sel(MTR_SEL_BUF_CFG, 8'h1C | 8'(c));
      keeps = 0;
      repeat (8) begin
        sample_i <= 1'b1;
        @(posedge clock_i);
        sample_i <= 1'b0;
        @(posedge clock_i);
      end
      @(posedge clock_i);
      `CHK(keeps, (c == 2) ? 2 : (c == 1) ? 4 : 8)
    end
    wr(MTR_ADDR_LOCK_KEY, 8'h55);
    `CHK(unlocked, 1'b0)
    wr(MTR_ADDR_CTRL_SEL, 8'h03);
    rd(MTR_ADDR_CTRL_SEL);
    `CHK(q, 8'h0B)
    wr(MTR_ADDR_CTRL_DATA, 8'h00);
    `CHK(buf_ctl[3:1], 3'h7)
    rd(MTR_ADDR_LOCK_KEY);
    `CHK(q, 8'h55)
    rd(6'h3F);
    `CHK(q, 8'h00)
    complete_run();
  end
endmodule
